// ### core/tsoc_pkg.sv
package tsoc_pkg;

  // channel count of the unit
  localparam int TSOC_CHANS = 8;

  // register byte addresses
  localparam logic [19:0] ADDR_ENABLE_STATUS = 20'hF01B0;
  localparam logic [19:0] ADDR_START_TRIG = 20'hF01B2;
  localparam logic [19:0] ADDR_STOP_TRIG = 20'hF01B4;
  localparam logic [19:0] ADDR_OUT_VALUE = 20'hF01B8;
  localparam logic [19:0] ADDR_OUT_ENABLE = 20'hF01BA;
  localparam logic [19:0] ADDR_OUT_POLARITY = 20'hF01BC;
  localparam logic [19:0] ADDR_OUT_MODE = 20'hF01BE;

  // field positions in the trigger and status words
  localparam int UPPER_CH1_POS = 9;
  localparam int UPPER_CH3_POS = 11;

  // values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_UPPER = 2'h0;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // access widths of a cpu request
  typedef enum logic [1:0] {
    TSOC_ACC_WORD = 2'b00,
    TSOC_ACC_BYTE = 2'b01,
    TSOC_ACC_BIT = 2'b10
  } tsoc_acc_t;

  // one cpu register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    tsoc_acc_t size;
    logic [2:0] bitIdx;
    logic [15:0] wdata;
  } tsoc_req_t;

endpackage

// ### core/tsoc_out_chan.sv
`timescale 1ns/1ns
module tsoc_out_chan
  import tsoc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // channel settings
  input wire logic outEnable,
  input wire logic slaveMode,
  input wire logic activeLow,
  // software write of the value bit
  input wire logic swWrite,
  input wire logic swValue,
  // interrupt request pulses
  input wire logic ownIrq,
  input wire logic masterIrq,
  // output value bit, drives the pin
  output logic outBit_r
);

  logic outBit_nxt;

  // mode and polarity are sampled only at an event, so changes wait for the next set or reset event
  always_comb begin
    outBit_nxt = outBit_r;
    if (!outEnable) begin
      if (swWrite) begin
        outBit_nxt = swValue; // [RULE9]
      end
    end else if (!slaveMode) begin
      // polarity not consulted in master mode
      if (ownIrq) begin
        outBit_nxt = ~outBit_r; // [RULE18] [RULE16]
      end
    end else begin
      // set wins when both pulses coincide: full duty rather than a lost edge
      if (masterIrq) begin
        outBit_nxt = ~activeLow; // [RULE19] [RULE15] [RULE17] [RULE20]
      end else if (ownIrq) begin
        outBit_nxt = activeLow; // [RULE19] [RULE15]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outBit_r <= 1'b0; // [RULE8]
    end else begin
      outBit_r <= outBit_nxt; // [RULE10]
    end
  end

  chk_sw_takes: assert property (@(posedge clk) disable iff (!rst_b) // [RULE9]
    (!outEnable && swWrite) |=> (outBit_r == $past(swValue)))
    else $error("software write to disabled output not taken");

  chk_sw_ignored: assert property (@(posedge clk) disable iff (!rst_b) // [RULE10]
    (outEnable && swWrite && !ownIrq && !masterIrq) |=> $stable(outBit_r))
    else $error("software write changed an enabled output");

  chk_master_toggle: assert property (@(posedge clk) disable iff (!rst_b) // [RULE18]
    (outEnable && !slaveMode && ownIrq) |=> (outBit_r != $past(outBit_r)))
    else $error("master output did not toggle");

  chk_slave_set: assert property (@(posedge clk) disable iff (!rst_b) // [RULE19]
    (outEnable && slaveMode && masterIrq) |=> (outBit_r == !$past(activeLow)))
    else $error("slave output not set to active level");

  chk_slave_reset: assert property (@(posedge clk) disable iff (!rst_b) // [RULE15]
    (outEnable && slaveMode && !masterIrq && ownIrq) |=> (outBit_r == $past(activeLow)))
    else $error("slave output not reset to idle level");

  chk_level_waits: assert property (@(posedge clk) disable iff (!rst_b) // [RULE17]
    (outEnable && !ownIrq && !masterIrq) |=> $stable(outBit_r))
    else $error("enabled output changed without an event");

endmodule

// ### core/tsoc_ctrl.sv
// Function
// [RULE1] a 1 in a stop trigger bit clears that channel's run status; 0 does nothing
// [RULE2] stop trigger bits, upper-half ones too, self-clear at once after stopping
// [RULE3] reading the stop trigger register always returns zero
// [RULE4] bits 7..0 stop channels; bits 9 and 11 stop upper halves of 1 and 3
// [RULE5] in 8-bit mode a channel bit of 1 or 3 stops only the lower half
// [RULE6] software writes 0 to stop trigger bits 15..12, 10 and 8
// [RULE7] stop trigger and output enable take word, low byte and single-bit writes
// [RULE8] reset clears stop, enable, value, polarity and mode registers to zero
// [RULE9] output disabled: timer leaves value bit alone, software writes are taken
// [RULE10] output enabled: only timer events change value bit; software writes ignored
// [RULE11] software writes 0 to output enable bits 15..8
// [RULE12] each output value bit drives its channel's output pin directly
// [RULE13] software clears the value bit before using the pin as a port
// [RULE14] value, polarity and mode take word and low byte writes, no bit writes
// [RULE15] polarity bit 0 is active high, 1 is active low
// [RULE16] polarity applies only to enabled slave outputs, ignored in master mode
// [RULE17] a polarity change takes effect at the next set or reset
// [RULE18] master mode output toggles on the channel's own interrupt pulse
// [RULE19] slave mode output set by master pulse, reset by own pulse
// [RULE20] a mode change takes effect at the next set or reset event
// [RULE21] software sets mode 0 for independent and master channels, 1 for slaves
// [RULE22] software keeps bits 15..8 and bit 0 of polarity and mode at 0
// [RULE23] only channels 0, 2, 4 and 6 act as masters for slave outputs
// [RULE24] a 1 in a start trigger bit sets that channel's run status
// [RULE25] stopping an already stopped channel changes nothing
`timescale 1ns/1ns
module tsoc_ctrl
  import tsoc_pkg::*;
#(
  parameter int NUM_CHAN = TSOC_CHANS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // cpu register access
  input wire tsoc_req_t req,
  output logic [15:0] rdData_r,
  output logic rdValid_r,
  // counter side
  input wire logic [7:0] chanIrq,
  input wire logic [1:0] eightBitMode,
  output logic [7:0] chanRun_r,
  output logic [1:0] upperRun_r,
  // timer output pins
  output logic [7:0] timerOut
);

  if (NUM_CHAN != TSOC_CHANS) begin : gen_bad_chan
    $error("tsoc_ctrl serves exactly eight channels");
  end

  // low byte after a write of the given width
  function automatic logic [7:0] mergeLow(input logic [7:0] old, input tsoc_req_t r,
                                          input logic allowBit);
    logic [7:0] res;
    res = old;
    case (r.size)
      TSOC_ACC_WORD: res = r.wdata[7:0];
      TSOC_ACC_BYTE: res = r.wdata[7:0];
      TSOC_ACC_BIT: begin
        if (allowBit) begin
          res[r.bitIdx] = r.wdata[0];
        end
      end
      default: res = old;
    endcase
    return res;
  endfunction

  // even channel just below a slave; odd-free so only 0, 2, 4, 6 qualify
  function automatic int masterOf(input int ch);
    return (ch == 0) ? 0 : ((ch - 1) & ~1); // [RULE23]
  endfunction

  logic wrStop, wrStart, wrEnable, wrValue, wrPolarity, wrMode, wordWr;
  logic [7:0] stopLow, startLow;
  logic [1:0] stopUpper, startUpper;
  logic [7:0] chanRun_nxt;
  logic [1:0] upperRun_nxt;
  logic [7:0] outEnable_r, outEnable_nxt;
  logic [7:0] polarity_r, polarity_nxt;
  logic [7:0] outMode_r, outMode_nxt;
  logic [7:0] valueWrite;
  logic [15:0] rdData_nxt;
  logic rdValid_nxt;

  assign wordWr = req.wr && (req.size == TSOC_ACC_WORD);
  assign wrStop = req.wr && (req.addr == ADDR_STOP_TRIG);
  assign wrStart = req.wr && (req.addr == ADDR_START_TRIG);
  assign wrEnable = req.wr && (req.addr == ADDR_OUT_ENABLE);
  assign wrValue = req.wr && (req.addr == ADDR_OUT_VALUE) && (req.size != TSOC_ACC_BIT); // [RULE14]
  assign wrPolarity = req.wr && (req.addr == ADDR_OUT_POLARITY) && (req.size != TSOC_ACC_BIT);
  assign wrMode = req.wr && (req.addr == ADDR_OUT_MODE) && (req.size != TSOC_ACC_BIT);

  // triggers have no storage: they act in the write cycle and are gone
  always_comb begin
    stopLow = wrStop ? mergeLow(RESET_BYTE, req, 1'b1) : RESET_BYTE; // [RULE7] [RULE2]
    startLow = wrStart ? mergeLow(RESET_BYTE, req, 1'b1) : RESET_BYTE;
    stopUpper = RESET_UPPER;
    startUpper = RESET_UPPER;
    // upper-half triggers sit in the high byte, so only word writes reach them
    if (wrStop && wordWr) begin
      stopUpper = {req.wdata[UPPER_CH3_POS], req.wdata[UPPER_CH1_POS]} & eightBitMode; // [RULE4]
    end
    if (wrStart && wordWr) begin
      startUpper = {req.wdata[UPPER_CH3_POS], req.wdata[UPPER_CH1_POS]} & eightBitMode;
    end
  end

  // run status: start sets, stop clears, zeros leave it alone
  always_comb begin
    chanRun_nxt = (chanRun_r | startLow) & ~stopLow; // [RULE1] [RULE24] [RULE25]
    upperRun_nxt = (upperRun_r | startUpper) & ~stopUpper; // [RULE4] [RULE5]
  end

  // output control registers; bit 0 of polarity and mode is held at 0
  always_comb begin
    outEnable_nxt = wrEnable ? mergeLow(outEnable_r, req, 1'b1) : outEnable_r; // [RULE7]
    polarity_nxt = wrPolarity ? mergeLow(polarity_r, req, 1'b0) : polarity_r; // [RULE14]
    outMode_nxt = wrMode ? mergeLow(outMode_r, req, 1'b0) : outMode_r; // [RULE14]
    polarity_nxt[0] = 1'b0; // [RULE22]
    outMode_nxt[0] = 1'b0; // [RULE22]
    valueWrite = wrValue ? req.wdata[7:0] : timerOut;
  end

  // read mux; unmapped addresses and trigger registers read as zero
  always_comb begin
    rdData_nxt = RESET_WORD;
    rdValid_nxt = req.rd;
    if (req.rd) begin
      case (req.addr)
        ADDR_ENABLE_STATUS: begin
          rdData_nxt[7:0] = chanRun_r;
          rdData_nxt[UPPER_CH1_POS] = upperRun_r[0];
          rdData_nxt[UPPER_CH3_POS] = upperRun_r[1];
        end
        ADDR_STOP_TRIG: rdData_nxt = RESET_WORD; // [RULE3]
        ADDR_START_TRIG: rdData_nxt = RESET_WORD;
        ADDR_OUT_VALUE: rdData_nxt[7:0] = timerOut;
        ADDR_OUT_ENABLE: rdData_nxt[7:0] = outEnable_r;
        ADDR_OUT_POLARITY: rdData_nxt[7:0] = polarity_r;
        ADDR_OUT_MODE: rdData_nxt[7:0] = outMode_r;
        default: rdData_nxt = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chanRun_r <= RESET_BYTE;
      upperRun_r <= RESET_UPPER;
      outEnable_r <= RESET_BYTE; // [RULE8]
      polarity_r <= RESET_BYTE; // [RULE8]
      outMode_r <= RESET_BYTE; // [RULE8]
      rdData_r <= RESET_WORD;
      rdValid_r <= 1'b0;
    end else begin
      chanRun_r <= chanRun_nxt;
      upperRun_r <= upperRun_nxt;
      outEnable_r <= outEnable_nxt;
      polarity_r <= polarity_nxt;
      outMode_r <= outMode_nxt;
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // one output stage per channel; its flop is the pin driver
  for (genvar ch = 0; ch < TSOC_CHANS; ch++) begin : gen_out
    tsoc_out_chan u_out (
      .clk(clk),
      .rst_b(rst_b),
      .outEnable(outEnable_r[ch]),
      .slaveMode(outMode_r[ch]),
      .activeLow(polarity_r[ch]),
      .swWrite(wrValue),
      .swValue(valueWrite[ch]),
      .ownIrq(chanIrq[ch]),
      .masterIrq(chanIrq[masterOf(ch)]), // [RULE23]
      .outBit_r(timerOut[ch]) // [RULE12]
    );
  end

  chk_stop_clears: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
    (wrStop && wordWr && req.wdata[0]) |=> !chanRun_r[0])
    else $error("stop trigger did not clear run status");

  chk_stop_zero: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
    (wrStop && wordWr && (req.wdata[7:0] == 8'h00) && !wrStart) |=> $stable(chanRun_r))
    else $error("zero stop write changed run status");

  chk_stop_reads: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
    (req.rd && (req.addr == ADDR_STOP_TRIG)) |=> (rdValid_r && (rdData_r == 16'h0000)))
    else $error("stop trigger register read nonzero");

  chk_upper_stop: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
    (wrStop && wordWr && req.wdata[UPPER_CH1_POS] && eightBitMode[0]) |=> !upperRun_r[0])
    else $error("upper half of channel 1 not stopped");

  chk_lower_only: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
    (wrStop && wordWr && req.wdata[3] && !req.wdata[UPPER_CH3_POS])
      |=> (!chanRun_r[3] && (upperRun_r[1] == $past(upperRun_r[1]))))
    else $error("channel stop bit touched the upper half");

  chk_start_sets: assert property (@(posedge clk) disable iff (!rst_b) // [RULE24]
    (wrStart && wordWr && req.wdata[2]) |=> chanRun_r[2])
    else $error("start trigger did not set run status");

  chk_enable_bit: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
    (wrEnable && (req.size == TSOC_ACC_BIT) && (req.bitIdx == 3'h3))
      |=> ((outEnable_r[3] == $past(req.wdata[0])) && (outEnable_r[2:0] == $past(outEnable_r[2:0]))))
    else $error("single-bit write to output enable misapplied");

  chk_value_nobit: assert property (@(posedge clk) disable iff (!rst_b) // [RULE14]
    (req.wr && (req.addr == ADDR_OUT_VALUE) && (req.size == TSOC_ACC_BIT)
      && (outEnable_r == 8'h00)) |=> $stable(timerOut))
    else $error("bit write changed the output value register");

endmodule

// ### testbench/tsoc_ctrl_tb_top.sv
`timescale 1ns/1ns
module tsoc_ctrl_tb_top;
  import tsoc_pkg::*;
  logic clk, rst_b, rdValid;
  tsoc_req_t req;
  logic [15:0] rdData;
  logic [7:0] chanIrq, chanRun, timerOut;
  logic [1:0] eightBitMode, upperRun;
  int failures, tests_run;

  tsoc_ctrl dut_u (
    .clk(clk), .rst_b(rst_b), .req(req), .rdData_r(rdData), .rdValid_r(rdValid),
    .chanIrq(chanIrq), .eightBitMode(eightBitMode), .chanRun_r(chanRun),
    .upperRun_r(upperRun), .timerOut(timerOut));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // request held for exactly one taking edge
  task automatic wr(input logic [19:0] a, input tsoc_acc_t s, input logic [15:0] d,
                    input logic [2:0] b = 3'h0);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.size <= s;
    req.bitIdx <= b;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input string name, input logic [19:0] a, input logic [15:0] exp);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk({name, " valid"}, 16'h0001, {15'h0000, rdValid});
    chk(name, exp, rdData);
  endtask

  task automatic irq(input logic [7:0] m);
    @(posedge clk);
    chanIrq <= m;
    @(posedge clk);
    chanIrq <= 8'h00;
    #1;
  endtask

  task automatic t_reset;
    rdchk("stop reg", ADDR_STOP_TRIG, 16'h0000);
    rdchk("value reg", ADDR_OUT_VALUE, 16'h0000);
    rdchk("enable reg", ADDR_OUT_ENABLE, 16'h0000);
    rdchk("polarity reg", ADDR_OUT_POLARITY, 16'h0000);
    rdchk("mode reg", ADDR_OUT_MODE, 16'h0000);
    chk("pins after reset", 16'h0000, {8'h00, timerOut});
  endtask

  task automatic t_stop;
    wr(ADDR_START_TRIG, TSOC_ACC_WORD, 16'h0AFF);
    chk("run after start", 16'h00FF, {8'h00, chanRun});
    chk("upper after start", 16'h0003, {14'h0000, upperRun});
    wr(ADDR_STOP_TRIG, TSOC_ACC_WORD, 16'h0001);
    chk("run stop ch0", 16'h00FE, {8'h00, chanRun});
    wr(ADDR_STOP_TRIG, TSOC_ACC_BYTE, 16'h0002);
    chk("run stop ch1 low", 16'h00FC, {8'h00, chanRun});
    chk("upper kept", 16'h0003, {14'h0000, upperRun});
    wr(ADDR_STOP_TRIG, TSOC_ACC_WORD, 16'h0200);
    chk("upper stop ch1", 16'h0002, {14'h0000, upperRun});
    wr(ADDR_STOP_TRIG, TSOC_ACC_BIT, 16'h0001, 3'h7);
    chk("run bit stop ch7", 16'h007C, {8'h00, chanRun});
    wr(ADDR_STOP_TRIG, TSOC_ACC_WORD, 16'h0000);
    chk("run zero write", 16'h007C, {8'h00, chanRun});
    wr(ADDR_STOP_TRIG, TSOC_ACC_WORD, 16'h0001);
    chk("run stop again", 16'h007C, {8'h00, chanRun});
    rdchk("stop reg read", ADDR_STOP_TRIG, 16'h0000);
    wr(ADDR_STOP_TRIG, TSOC_ACC_WORD, 16'h0800);
    chk("upper stop ch3", 16'h0000, {14'h0000, upperRun});
    // upper halves only exist in 8-bit mode
    eightBitMode <= 2'b00;
    wr(ADDR_START_TRIG, TSOC_ACC_WORD, 16'h0A00);
    chk("upper ignored 16-bit", 16'h0000, {14'h0000, upperRun});
    eightBitMode <= 2'b11;
    rdchk("unmapped", 20'hF01C0, 16'h0000);
  endtask

  task automatic t_swout;
    wr(ADDR_OUT_VALUE, TSOC_ACC_BYTE, 16'h00A5);
    chk("pins sw byte", 16'h00A5, {8'h00, timerOut});
    wr(ADDR_OUT_VALUE, TSOC_ACC_BIT, 16'h0001, 3'h1);
    chk("pins bit write", 16'h00A5, {8'h00, timerOut});
    rdchk("value read", ADDR_OUT_VALUE, 16'h00A5);
    wr(ADDR_OUT_VALUE, TSOC_ACC_WORD, 16'h0000);
    chk("pins parked low", 16'h0000, {8'h00, timerOut});
  endtask

  task automatic t_master;
    wr(ADDR_OUT_ENABLE, TSOC_ACC_BIT, 16'h0001, 3'h0);
    rdchk("enable bit write", ADDR_OUT_ENABLE, 16'h0001);
    irq(8'h01);
    chk("toggle up", 16'h0001, {8'h00, timerOut});
    irq(8'h01);
    chk("toggle down", 16'h0000, {8'h00, timerOut});
    wr(ADDR_OUT_VALUE, TSOC_ACC_WORD, 16'h0001);
    chk("sw write enabled", 16'h0000, {8'h00, timerOut});
    irq(8'h02);
    chk("irq disabled ch", 16'h0000, {8'h00, timerOut});
  endtask

  // slaves 1,3,5,7 fed by masters 0,2,4,6
  task automatic t_slave;
    wr(ADDR_OUT_ENABLE, TSOC_ACC_WORD, 16'h00FF);
    wr(ADDR_OUT_MODE, TSOC_ACC_WORD, 16'h00AA);
    irq(8'h55);
    chk("slave set", 16'h00FF, {8'h00, timerOut});
    irq(8'hAA);
    chk("slave reset", 16'h0055, {8'h00, timerOut});
    wr(ADDR_OUT_POLARITY, TSOC_ACC_WORD, 16'h0002);
    chk("polarity deferred", 16'h0055, {8'h00, timerOut});
    irq(8'h01);
    chk("low set", 16'h0054, {8'h00, timerOut});
    irq(8'h02);
    chk("low reset", 16'h0056, {8'h00, timerOut});
    wr(ADDR_OUT_POLARITY, TSOC_ACC_BYTE, 16'h0004);
    irq(8'h04);
    chk("master ignores pol", 16'h005A, {8'h00, timerOut});
    wr(ADDR_OUT_MODE, TSOC_ACC_WORD, 16'h002A);
    chk("mode deferred", 16'h005A, {8'h00, timerOut});
    irq(8'h80);
    chk("mode at event", 16'h00DA, {8'h00, timerOut});
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // whole run is under a hundred cycles; this is far beyond it
  initial begin
    #100000;
    failures++;
    wrap_up();
  end

  initial begin
    failures = 0;
    tests_run = 0;
    rst_b = 1'b0;
    req = '0;
    chanIrq = 8'h00;
    eightBitMode = 2'b11;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_stop();
    t_swout();
    t_master();
    t_slave();
    wrap_up();
  end
endmodule
